/* glt_pkg.sv */
// package for the gpio lookup-table logic: register map, reset values,
// mode codes and the carrier structs shared by all design files.
// assumes nothing of its surroundings.
package glt_pkg;

  // register bus
  localparam int unsigned GLT_ADDR_W = 8;
  localparam int unsigned GLT_DATA_W = 8;

  // table register offsets
  localparam logic [7:0] GLT_ADDR_T2_B  = 8'h22;
  localparam logic [7:0] GLT_ADDR_T2_A  = 8'h23;
  localparam logic [7:0] GLT_ADDR_T3_HB = 8'h24;
  localparam logic [7:0] GLT_ADDR_T3_HA = 8'h25;
  localparam logic [7:0] GLT_ADDR_T3_LB = 8'h26;

  // reset values
  localparam logic [7:0] GLT_RST_TABLE  = 8'h00;
  localparam logic [7:0] GLT_RD_UNMAPPED = 8'h00;

  // per-nibble mode selector codes
  localparam logic [1:0] GLT_MODE_GPIO  = 2'h0;
  localparam logic [1:0] GLT_MODE_TWO   = 2'h1;
  localparam logic [1:0] GLT_MODE_THREE = 2'h2;
  localparam logic [1:0] GLT_MODE_PAIR  = 2'h3;

  // port geometry
  localparam int unsigned GLT_NIBBLES  = 4;
  localparam int unsigned GLT_IO_W     = 16;
  localparam int unsigned GLT_TAB2_W   = 4;
  localparam int unsigned GLT_TAB3_W   = 8;
  localparam int unsigned GLT_TWO_PIN  = 2;
  localparam int unsigned GLT_THR_PIN  = 3;

  // one register access per cycle
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [GLT_ADDR_W-1:0] addr;
    logic [GLT_DATA_W-1:0] wdata;
  } glt_reg_req_t;

  // held truth tables
  typedef struct packed {
    logic [7:0] t2_b;
    logic [7:0] t2_a;
    logic [7:0] t3_hb;
    logic [7:0] t3_ha;
    logic [7:0] t3_lb;
  } glt_tables_t;

endpackage : glt_pkg

/* glt_table_regs.sv */
// truth-table register file: five read/write table registers.
// assumes one request per cycle from the device's register logic;
// read data is registered and unmapped reads answer zero.
`timescale 1ns/100ps
`default_nettype none
module glt_table_regs
  import glt_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // request
  input  wire glt_pkg::glt_reg_req_t  reg_req,
  // tables and read answer
  output glt_pkg::glt_tables_t        tables,
  output logic [glt_pkg::GLT_DATA_W-1:0] rd_data,
  output logic                        rd_valid
);

  glt_tables_t                tab_reg;
  logic [GLT_DATA_W-1:0]      rd_data_reg;
  logic [GLT_DATA_W-1:0]      rd_data_next;
  logic                       rd_valid_reg;

  // writes land on the edge, so a table change reaches the pins next cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tab_reg <= '{GLT_RST_TABLE, GLT_RST_TABLE, GLT_RST_TABLE, GLT_RST_TABLE,
                   GLT_RST_TABLE};
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        GLT_ADDR_T2_B:  tab_reg.t2_b  <= reg_req.wdata;
        GLT_ADDR_T2_A:  tab_reg.t2_a  <= reg_req.wdata;
        GLT_ADDR_T3_HB: tab_reg.t3_hb <= reg_req.wdata;
        GLT_ADDR_T3_HA: tab_reg.t3_ha <= reg_req.wdata;
        GLT_ADDR_T3_LB: tab_reg.t3_lb <= reg_req.wdata;
        default:        tab_reg       <= tab_reg;
      endcase
    end
  end

  always_comb begin
    unique case (reg_req.addr)
      GLT_ADDR_T2_B:  rd_data_next = tab_reg.t2_b;
      GLT_ADDR_T2_A:  rd_data_next = tab_reg.t2_a;
      GLT_ADDR_T3_HB: rd_data_next = tab_reg.t3_hb;
      GLT_ADDR_T3_HA: rd_data_next = tab_reg.t3_ha;
      GLT_ADDR_T3_LB: rd_data_next = tab_reg.t3_lb;
      default:        rd_data_next = GLT_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_reg  <= GLT_RD_UNMAPPED;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= reg_req.rd ? rd_data_next : rd_data_reg;
      rd_valid_reg <= reg_req.rd;
    end
  end

  assign tables   = tab_reg;
  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;

endmodule : glt_table_regs
`default_nettype wire

/* glt_lut_cell.sv */
// one nibble of lookup logic: decodes the mode selector and picks the
// table bit for the 2-to-1 line (nibble bit 2) and 3-to-1 line (bit 3).
// purely combinational; the parent registers the results.
`timescale 1ns/100ps
`default_nettype none
module glt_lut_cell
  import glt_pkg::*;
#(
  parameter bit HAS_THREE = 1'b1
) (
  // selector and index lines
  input  wire logic [1:0]                     mode,
  input  wire logic [2:0]                     idx,
  // tables
  input  wire logic [glt_pkg::GLT_TAB2_W-1:0] tab2,
  input  wire logic [glt_pkg::GLT_TAB3_W-1:0] tab3,
  // decoded drive
  output logic                                drv_two,
  output logic                                en_two,
  output logic                                drv_three,
  output logic                                en_three
);

  // code 11 (3-to-2 below, reserved above) drives nothing from here
  always_comb begin
    en_two    = (mode == GLT_MODE_TWO);
    en_three  = HAS_THREE && (mode == GLT_MODE_THREE);
    drv_two   = en_two   ? tab2[idx[1:0]] : 1'b0;
    drv_three = en_three ? tab3[idx]      : 1'b0;
  end

endmodule : glt_lut_cell
`default_nettype wire

/* glt_lookup_logic.sv */
// top of the gpio lookup-table logic: table registers, per-nibble lookup
// cells and registered pin drive for a 16-line expander.
// assumes register requests come from the device's serial register logic
// and that pin inputs are synchronous to sys_clk.
//
// Notes on behaviour
// [R1] in 2-to-1 mode for lines 15:12, line 14 takes bit 4+n of the 2-to-1 b table, n = 13:12.
// [R2] in 2-to-1 mode for lines 11:8, line 10 takes bit n of the 2-to-1 b table, n = lines 9:8.
// [R3] in 2-to-1 mode for lines 7:4, line 6 takes bit 4+n of the 2-to-1 a table, n = lines 5:4.
// [R4] in 2-to-1 mode for lines 3:0, line 2 takes bit n of the 2-to-1 a table, n = lines 1:0.
// [R5] in 3-to-1 mode for lines 15:12, line 15 takes bit n of the high b 3-to-1 table, n = 14:12.
// [R6] in 3-to-1 mode for lines 7:4, line 7 takes bit n of the high a 3-to-1 table, n = lines 6:4.
// [R7] in 3-to-1 mode for lines 11:8, line 11 takes bit n of the low b 3-to-1 table, n = 10:8.
// [R8] a table only affects its line while its nibble sits in the matching lookup mode.
// [R9] mode code 00 is plain gpio, 01 is 2-to-1, 10 is 3-to-1, 11 is 3-to-2 low or reserved high.
// [R10] the host keeps the unused mode-register bit pairs at zero.
// [R11] a lookup output follows an index change within one clock and a table write within two.
`timescale 1ns/100ps
`default_nettype none
module glt_lookup_logic
  import glt_pkg::*;
(
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // register access
  input  wire glt_pkg::glt_reg_req_t        reg_req,
  output logic [glt_pkg::GLT_DATA_W-1:0]    reg_rd_data,
  output logic                              reg_rd_valid,
  // nibble mode selectors
  input  wire logic [1:0]                   upper_nibble_b_logic_mode,
  input  wire logic [1:0]                   lower_nibble_b_logic_mode,
  input  wire logic [1:0]                   upper_nibble_a_logic_mode,
  input  wire logic [1:0]                   lower_nibble_a_logic_mode,
  // i/o lines
  input  wire logic [glt_pkg::GLT_IO_W-1:0] io_in,
  output logic [glt_pkg::GLT_IO_W-1:0]      lut_out,
  output logic [glt_pkg::GLT_IO_W-1:0]      lut_oe_n
);

  glt_tables_t                      tables;
  logic [2*GLT_NIBBLES-1:0]         mode_flat;
  logic [GLT_TAB2_W*GLT_NIBBLES-1:0] tab2_flat;
  logic [GLT_TAB3_W*GLT_NIBBLES-1:0] tab3_flat;
  logic [GLT_NIBBLES-1:0]           drv_two;
  logic [GLT_NIBBLES-1:0]           en_two;
  logic [GLT_NIBBLES-1:0]           drv_three;
  logic [GLT_NIBBLES-1:0]           en_three;
  logic [GLT_IO_W-1:0]              lut_out_reg;
  logic [GLT_IO_W-1:0]              lut_out_next;
  logic [GLT_IO_W-1:0]              lut_oe_n_reg;
  logic [GLT_IO_W-1:0]              lut_oe_n_next;

  glt_table_regs u_regs (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .reg_req  (reg_req),
    .tables   (tables),
    .rd_data  (reg_rd_data),
    .rd_valid (reg_rd_valid)
  );

  // nibble order 3..0 = upper b, lower b, upper a, lower a
  assign mode_flat = {upper_nibble_b_logic_mode, lower_nibble_b_logic_mode,
                      upper_nibble_a_logic_mode, lower_nibble_a_logic_mode};
  assign tab2_flat = {tables.t2_b, tables.t2_a};  // see [R1] see [R2] see [R3] see [R4]
  // lower a 3-to-1 table lives outside this block, so that cell has none
  assign tab3_flat = {tables.t3_hb, tables.t3_lb, tables.t3_ha,
                      GLT_RST_TABLE};  // see [R5] see [R6] see [R7]

  // unused mode bit pairs never reach here, so no masking is needed
  for (genvar k = 0; k < GLT_NIBBLES; k++) begin : g_nib
    glt_lut_cell #(
      .HAS_THREE (k != 0)
    ) u_cell (
      .mode      (mode_flat[2*k +: 2]),  // see [R9]
      .idx       (io_in[GLT_NIBBLES*k +: 3]),
      .tab2      (tab2_flat[GLT_TAB2_W*k +: GLT_TAB2_W]),
      .tab3      (tab3_flat[GLT_TAB3_W*k +: GLT_TAB3_W]),
      .drv_two   (drv_two[k]),
      .en_two    (en_two[k]),
      .drv_three (drv_three[k]),
      .en_three  (en_three[k])
    );
  end

  // lines not owned by a lookup stay released, leaving pin control to gpio
  always_comb begin
    lut_out_next  = '0;
    lut_oe_n_next = '1;
    for (int k = 0; k < GLT_NIBBLES; k++) begin
      lut_out_next[GLT_NIBBLES*k + GLT_TWO_PIN]  = drv_two[k];
      lut_oe_n_next[GLT_NIBBLES*k + GLT_TWO_PIN] = !en_two[k];  // see [R8]
      lut_out_next[GLT_NIBBLES*k + GLT_THR_PIN]  = drv_three[k];
      lut_oe_n_next[GLT_NIBBLES*k + GLT_THR_PIN] = !en_three[k];  // see [R8]
    end
  end

  // one register stage: glitch-free pins at the cost of one clock of lag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lut_out_reg  <= '0;
      lut_oe_n_reg <= '1;
    end else begin
      lut_out_reg  <= lut_out_next;  // see [R11]
      lut_oe_n_reg <= lut_oe_n_next;
    end
  end

  assign lut_out  = lut_out_reg;
  assign lut_oe_n = lut_oe_n_reg;

  // checking helpers
  logic exp_l14;
  logic exp_l10;
  logic exp_l6;
  logic exp_l2;
  logic exp_l15;
  logic exp_l7;
  logic exp_l11;

  assign exp_l14 = tables.t2_b[{1'b1, io_in[13:12]}];
  assign exp_l10 = tables.t2_b[{1'b0, io_in[9:8]}];
  assign exp_l6  = tables.t2_a[{1'b1, io_in[5:4]}];
  assign exp_l2  = tables.t2_a[{1'b0, io_in[1:0]}];
  assign exp_l15 = tables.t3_hb[io_in[14:12]];
  assign exp_l7  = tables.t3_ha[io_in[6:4]];
  assign exp_l11 = tables.t3_lb[io_in[10:8]];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_two_upper_b: assert property ( // see [R1]
    upper_nibble_b_logic_mode == GLT_MODE_TWO
      |=> !lut_oe_n[14] && lut_out[14] == $past(exp_l14))
    else $error("line 14 does not follow the 2-to-1 b table");

  a_two_lower_b: assert property ( // see [R2]
    lower_nibble_b_logic_mode == GLT_MODE_TWO
      |=> !lut_oe_n[10] && lut_out[10] == $past(exp_l10))
    else $error("line 10 does not follow the 2-to-1 b table");

  a_two_upper_a: assert property ( // see [R3]
    upper_nibble_a_logic_mode == GLT_MODE_TWO
      |=> !lut_oe_n[6] && lut_out[6] == $past(exp_l6))
    else $error("line 6 does not follow the 2-to-1 a table");

  a_two_lower_a: assert property ( // see [R4]
    lower_nibble_a_logic_mode == GLT_MODE_TWO
      |=> !lut_oe_n[2] && lut_out[2] == $past(exp_l2))
    else $error("line 2 does not follow the 2-to-1 a table");

  a_three_high_b: assert property ( // see [R5]
    upper_nibble_b_logic_mode == GLT_MODE_THREE
      |=> !lut_oe_n[15] && lut_oe_n[14] && lut_out[15] == $past(exp_l15))
    else $error("line 15 does not follow the high b 3-to-1 table");

  a_three_high_a: assert property ( // see [R6]
    upper_nibble_a_logic_mode == GLT_MODE_THREE
      |=> !lut_oe_n[7] && lut_oe_n[6] && lut_out[7] == $past(exp_l7))
    else $error("line 7 does not follow the high a 3-to-1 table");

  a_three_low_b: assert property ( // see [R7]
    lower_nibble_b_logic_mode == GLT_MODE_THREE
      |=> !lut_oe_n[11] && lut_oe_n[10] && lut_out[11] == $past(exp_l11))
    else $error("line 11 does not follow the low b 3-to-1 table");

  a_gpio_mode_released: assert property ( // see [R8]
    upper_nibble_b_logic_mode == GLT_MODE_GPIO
      && lower_nibble_a_logic_mode == GLT_MODE_GPIO
      |=> lut_oe_n[15:12] == 4'hF && lut_oe_n[3:0] == 4'hF)
    else $error("a table drives a line while its nibble is plain gpio");

  a_code_three_idle: assert property ( // see [R9]
    upper_nibble_a_logic_mode == GLT_MODE_PAIR
      && lower_nibble_b_logic_mode == GLT_MODE_PAIR
      |=> lut_oe_n[7:4] == 4'hF && lut_oe_n[11:8] == 4'hF)
    else $error("code 11 drives a line from these tables");

  a_write_reaches_pin: assert property ( // see [R11]
    reg_req.wr && reg_req.addr == GLT_ADDR_T2_B
      && upper_nibble_b_logic_mode == GLT_MODE_TWO
      ##1 upper_nibble_b_logic_mode == GLT_MODE_TWO
      && io_in[13:12] == $past(io_in[13:12])
      |=> lut_out[14] == $past(reg_req.wdata[{1'b1, io_in[13:12]}], 2))
    else $error("written table bit missing from line 14 two cycles on");

  a_unmapped_reads_zero: assert property (
    reg_req.rd && reg_req.addr > GLT_ADDR_T3_LB
      |=> reg_rd_valid && reg_rd_data == GLT_RD_UNMAPPED)
    else $error("unmapped read did not answer zero");

  c_two_to_one: cover property (
    upper_nibble_a_logic_mode == GLT_MODE_TWO ##1 lut_out[6]);

  c_three_to_one: cover property (
    lower_nibble_b_logic_mode == GLT_MODE_THREE ##1 lut_out[11]);

  c_table_write: cover property (
    reg_req.wr && reg_req.addr == GLT_ADDR_T3_HB);

  c_mode_change: cover property (
    upper_nibble_b_logic_mode == GLT_MODE_TWO
      ##1 upper_nibble_b_logic_mode == GLT_MODE_THREE);

endmodule : glt_lookup_logic
`default_nettype wire

/* glt_host_model.sv */
// host controller model: issues table writes/reads and sets nibble modes.
// assumes the lookup block answers reads on the taking edge, one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module glt_host_model
  import glt_pkg::*;
(
  // clock
  input  wire logic                          sys_clk,
  // register access
  output glt_pkg::glt_reg_req_t              reg_req,
  input  wire logic [glt_pkg::GLT_DATA_W-1:0] rd_data,
  input  wire logic                          rd_valid,
  // nibble modes
  output logic [1:0]                         upper_nibble_b_logic_mode,
  output logic [1:0]                         lower_nibble_b_logic_mode,
  output logic [1:0]                         upper_nibble_a_logic_mode,
  output logic [1:0]                         lower_nibble_a_logic_mode
);
  import glt_pkg::*;

  initial begin
    reg_req = '0;
    set_now(8'h00, 8'h00);
  end

  task automatic set_now(input logic [7:0] b, input logic [7:0] a);
    // reserved pairs 7:6 and 3:2 are never passed on, so they stay zero
    upper_nibble_b_logic_mode = b[5:4];
    lower_nibble_b_logic_mode = b[1:0];
    upper_nibble_a_logic_mode = a[5:4];
    lower_nibble_a_logic_mode = a[1:0];
  endtask : set_now

  task automatic set_modes(input logic [7:0] b, input logic [7:0] a);
    @(negedge sys_clk);
    set_now(b, a);
  endtask : set_modes

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req = '0;
  endtask : write_reg

  // returns {valid, data} as seen in the answer cycle
  task automatic read_reg(input logic [7:0] a, output logic [8:0] r);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    r = {rd_valid, rd_data};
    reg_req = '0;
  endtask : read_reg
endmodule : glt_host_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the lookup-table logic.
// assumes the host model drives requests and modes at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import glt_pkg::*;

  logic                 sys_clk;
  logic                 rst;
  glt_reg_req_t         reg_req;
  logic [7:0]           rd_data;
  logic                 rd_valid;
  logic [1:0]           m_hb, m_lb, m_ha, m_la;
  logic [15:0]          io_in, lut_out, lut_oe_n;
  logic [7:0]           tab [5];
  logic [8:0]           r;
  logic [31:0]          rv;
  logic [7:0]           iv, d, mv;
  int                   n_errors, n_tests, cyc, i, k;
  integer               seed = 14762;

  glt_lookup_logic DUT (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
    .upper_nibble_b_logic_mode(m_hb), .lower_nibble_b_logic_mode(m_lb),
    .upper_nibble_a_logic_mode(m_ha), .lower_nibble_a_logic_mode(m_la),
    .io_in(io_in), .lut_out(lut_out), .lut_oe_n(lut_oe_n));

  glt_host_model host (.sys_clk(sys_clk), .reg_req(reg_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .upper_nibble_b_logic_mode(m_hb),
    .lower_nibble_b_logic_mode(m_lb), .upper_nibble_a_logic_mode(m_ha),
    .lower_nibble_a_logic_mode(m_la));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // mv = {hb, lb, ha, la}; returns {drive, active-low enable}
  function automatic logic [31:0] exp_lut(input logic [15:0] io, input logic [7:0] mv);
    logic [15:0] o;
    logic [15:0] e;
    logic [2:0]  ix;
    logic [7:0]  t;
    o = '0;
    e = '1;
    for (int n = 0; n < 4; n++) begin
      ix = io[4*n +: 3];
      if (mv[2*n +: 2] == GLT_MODE_TWO) begin
        t = (n >= 2) ? tab[0] : tab[1];
        e[4*n+2] = 1'b0;
        o[4*n+2] = t[(n % 2) * 4 + ix[1:0]];
      end
      // lower-a 3-to-1 table lives outside this block
      if (mv[2*n +: 2] == GLT_MODE_THREE && n != 0) begin
        t = (n == 3) ? tab[2] : ((n == 2) ? tab[4] : tab[3]);
        e[4*n+3] = 1'b0;
        o[4*n+3] = t[ix];
      end
    end
    return {o, e};
  endfunction : exp_lut

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    io_in = 16'h0000;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    // reset values, unmapped offset 0x27 included
    for (i = 0; i < 6; i++) begin
      host.read_reg(GLT_ADDR_T2_B + i[7:0], r);
      chk({23'h0, r}, {23'h0, 1'b1, GLT_RST_TABLE});
      if (i < 5) tab[i] = GLT_RST_TABLE;
    end
    chk({lut_out, lut_oe_n}, {16'h0000, 16'hFFFF});
    // table writes, then an unmapped write that must not disturb the readback
    for (i = 0; i < 5; i++) begin
      rv = $random(seed);
      tab[i] = rv[7:0];
      host.write_reg(GLT_ADDR_T2_B + i[7:0], tab[i]);
    end
    host.write_reg(8'h27, 8'hA5);
    for (i = 0; i < 6; i++) begin
      host.read_reg(GLT_ADDR_T2_B + i[7:0], r);
      chk({23'h0, r}, {23'h0, 1'b1, (i < 5) ? tab[i] : GLT_RD_UNMAPPED});
    end
    // every mode code on every nibble, random pins and table updates
    for (i = 0; i < 256; i++) begin
      iv = i[7:0];
      if (i % 4 == 0) begin
        rv = $random(seed);
        k = rv[3:0] % 5;
        d = rv[15:8];
        host.write_reg(GLT_ADDR_T2_B + k[7:0], d);
        tab[k] = d;
      end
      host.set_modes({2'b00, iv[1:0], 2'b00, iv[3:2]}, {2'b00, iv[5:4], 2'b00, iv[7:6]});
      rv = $random(seed);
      io_in = rv[15:0];
      repeat (2) @(negedge sys_clk);
      mv = {iv[1:0], iv[3:2], iv[5:4], iv[7:6]};
      rv = exp_lut(io_in, mv);
      chk({16'h0, lut_out}, {16'h0, rv[31:16]});
      chk({16'h0, lut_oe_n}, {16'h0, rv[15:0]});
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
